// file: adc_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
// Assumes inclusion by the package and the design modules of this block.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define ADDR_W 4
`define REG_STATUS_CTRL 4'h0
`define REG_CONV_CLOCK 4'h1
`define REG_RESULT_HI 4'h2
`define REG_RESULT_LO 4'h3
`define REG_PIN_ENABLE 4'h4
`define REG_STOP_MODE 4'h5

`define SC_DONE_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CONT_BIT 5
`define SC_CHAN_MSB 4
`define SC_CHAN_LSB 0

`define CK_LOW_POWER_BIT 7
`define CK_DIV_MSB 6
`define CK_DIV_LSB 5
`define CK_LONG_SAMPLE_BIT 4
`define CK_ASYNC_EN_BIT 0

`define STATUS_CTRL_RESET 8'h1F
`define CONV_CLOCK_RESET 8'h00

`define SAMPLE_SHORT_CYC 6'h09
`define SAMPLE_LONG_CYC 6'h17
`define ASYNC_SETUP_CYC 6'h05
`define BIT_COUNT 4'hA
`define ASYNC_DIV 4'h2
`define CHAN_OFF 5'h1F
`define TICK_LIMIT_MIN 4'h2
`define CONV_MIN_CYC 6'h15
`define CONV_MAX_CYC 6'h2C

`endif

// file: adc_ctrl_pkg.sv
// Types shared by the converter control modules.
// Assumes the register header is on the include path.
package adc_ctrl_pkg;
  `include "adc_ctrl_regs.svh"
  typedef logic [7:0] byte_t;
  typedef logic [9:0] result_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_SETUP = 5'b0_0010,
    ST_SAMPLE = 5'b0_0100,
    ST_CONVERT = 5'b0_1000,
    ST_FINISH = 5'b1_0000
  } conv_state_e;
endpackage

// file: conv_clock_gen.sv
// Converter clock enable generator: divided bus clock or the internal asynchronous clock.
// Assumes one system clock; the asynchronous source is modelled as a fixed-rate tick on that clock.
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module conv_clock_gen (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Selection.
  input wire logic [1:0] div_sel_in,
  input wire logic async_sel_in,
  input wire logic run_in,
  // Tick.
  output logic tick_out
);
  import adc_ctrl_pkg::*;
  logic [3:0] count;
  wire [3:0] div_limit = async_sel_in ? `ASYNC_DIV : 4'((4'h1 << div_sel_in) - 4'h1);
  // The comparator answers through a two stage synchroniser, so ticks stay at least three cycles apart.
  wire [3:0] limit = (div_limit < `TICK_LIMIT_MIN) ? `TICK_LIMIT_MIN : div_limit;
  wire wrap = (count >= limit);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      count <= 4'h0;
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      count <= (!run_in || wrap) ? 4'h0 : 4'(count + 4'h1);
      tick_out <= run_in && wrap;
    end
  end
endmodule

// file: adc_conversion_control.sv
// Control logic of the ten bit successive approximation converter with its register port.
// Assumes a comparator input from the analogue front end and a stop request from the processor.
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module adc_conversion_control (
  // Clock, reset, enable.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Register port.
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire adc_ctrl_pkg::byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output adc_ctrl_pkg::byte_t rdata_out,
  // Processor state.
  input wire logic stop_mode_in,
  // Analogue front end.
  input wire logic comp_in,
  output logic [4:0] mux_sel_out,
  output logic sample_out,
  output logic low_power_out,
  output adc_ctrl_pkg::result_t dac_code_out,
  // Pin control and interrupt.
  output logic analog_ch_enable_out,
  output logic conv_irq_out
);
  import adc_ctrl_pkg::*;

  logic conv_done_flag;
  logic conv_irq_enable;
  logic continuous;
  logic [4:0] channel;
  logic low_power_config;
  logic [1:0] clk_div;
  logic long_sample_select;
  logic async_clock_enable;
  result_t result;
  result_t sar;
  logic [3:0] bit_idx;
  logic [5:0] phase_cnt;
  conv_state_e state;
  conv_state_e next_state;
  logic comp_meta;
  logic comp_sync;
  logic stop_meta;
  logic stop_sync;
  logic tick;

  // Inputs from outside the clock domain pass two flip-flops.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      stop_meta <= 1'b0;
      stop_sync <= 1'b0;
    end else if (clk_en_in) begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
      stop_meta <= stop_mode_in;
      stop_sync <= stop_meta;
    end
  end

  wire wr_sc = wr_in && (addr_in == `REG_STATUS_CTRL);
  wire wr_ck = wr_in && (addr_in == `REG_CONV_CLOCK);
  wire rd_lo = rd_in && (addr_in == `REG_RESULT_LO);
  wire chan_on = (channel != `CHAN_OFF);
  wire frozen = stop_sync && !async_clock_enable;
  wire running = (state != ST_IDLE) && !frozen;
  // A tick launched just before a freeze is dropped, so the sequencer stops on the spot.
  wire step = tick && running;
  wire [5:0] sample_len = long_sample_select ? `SAMPLE_LONG_CYC : `SAMPLE_SHORT_CYC;
  wire phase_end = (phase_cnt == 6'h00);
  wire bit_end = (bit_idx == 4'h0);
  wire finish = step && (state == ST_FINISH);
  wire start = wr_sc && (wdata_in[`SC_CHAN_MSB:`SC_CHAN_LSB] != `CHAN_OFF);
  wire restart = finish && continuous && chan_on;
  wire [3:0] msb = 4'(`BIT_COUNT - 4'h1);
  wire [9:0] trial = 10'(10'h001 << bit_idx);
  wire [9:0] sar_keep = comp_sync ? sar : (sar & ~trial);
  wire [9:0] sar_next = bit_end ? sar_keep : (sar_keep | (trial >> 1));

  function automatic logic [9:0] trial_init();
    trial_init = 10'h200;
  endfunction

  // Sequencer: setup (async only), sample, ten bit decisions, finish.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_SETUP: if (phase_end) next_state = ST_SAMPLE;
      ST_SAMPLE: if (phase_end) next_state = ST_CONVERT;
      ST_CONVERT: if (bit_end) next_state = ST_FINISH;
      ST_FINISH: next_state = restart ? ST_SAMPLE : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  conv_clock_gen u_clk (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .div_sel_in(clk_div),
    .async_sel_in(async_clock_enable),
    .run_in(running),
    .tick_out(tick)
  );

  // Configuration registers; the done flag bit ignores the value written.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      {conv_irq_enable, continuous, channel} <= 7'(`STATUS_CTRL_RESET);
      {low_power_config, clk_div, long_sample_select} <= 4'h0;
      async_clock_enable <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_sc) begin
        conv_irq_enable <= wdata_in[`SC_IRQ_EN_BIT];
        continuous <= wdata_in[`SC_CONT_BIT];
        channel <= wdata_in[`SC_CHAN_MSB:`SC_CHAN_LSB];
      end
      if (wr_ck) begin
        low_power_config <= wdata_in[`CK_LOW_POWER_BIT];
        clk_div <= wdata_in[`CK_DIV_MSB:`CK_DIV_LSB];
        long_sample_select <= wdata_in[`CK_LONG_SAMPLE_BIT];
        async_clock_enable <= wdata_in[`CK_ASYNC_EN_BIT];
      end
    end
  end

  // Done flag: set on finish wins over the clear caused by a status and control write or a read of the low result byte.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      conv_done_flag <= 1'b0;
    end else if (clk_en_in) begin
      if (finish) begin
        conv_done_flag <= 1'b1;
      end else if (wr_sc || rd_lo) begin
        conv_done_flag <= 1'b0;
      end
    end
  end

  // Conversion datapath.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      phase_cnt <= 6'h00;
      bit_idx <= 4'h0;
      sar <= 10'h000;
      result <= 10'h000;
    end else if (clk_en_in) begin
      if (start) begin
        state <= async_clock_enable ? ST_SETUP : ST_SAMPLE;
        phase_cnt <= async_clock_enable ? `ASYNC_SETUP_CYC : sample_len;
        bit_idx <= msb;
        sar <= trial_init();
      end else if (wr_sc) begin
        state <= ST_IDLE;
      end else if (step) begin
        state <= next_state;
        phase_cnt <= phase_end ? sample_len : 6'(phase_cnt - 6'h01);
        if (state == ST_CONVERT) begin
          sar <= sar_next;
          bit_idx <= bit_end ? msb : 4'(bit_idx - 4'h1);
        end
        if (state == ST_FINISH) begin
          result <= sar;
          sar <= trial_init();
        end
      end
    end
  end

  // The trial code leaves straight from its register, sparing the comparator a cycle of settling.
  assign dac_code_out = sar;

  // Registered outputs.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      mux_sel_out <= `CHAN_OFF;
      sample_out <= 1'b0;
      low_power_out <= 1'b0;
      analog_ch_enable_out <= 1'b0;
      conv_irq_out <= 1'b0;
    end else if (clk_en_in) begin
      case (addr_in)
        `REG_STATUS_CTRL: rdata_out <= rd_in ? {conv_done_flag, conv_irq_enable, continuous, channel} : 8'h00;
        `REG_CONV_CLOCK: rdata_out <= rd_in ? {low_power_config, clk_div, long_sample_select, 3'b000,
          async_clock_enable} : 8'h00;
        `REG_RESULT_HI: rdata_out <= rd_in ? {6'h00, result[9:8]} : 8'h00;
        `REG_RESULT_LO: rdata_out <= rd_in ? result[7:0] : 8'h00;
        `REG_STOP_MODE: rdata_out <= rd_in ? {7'h00, stop_sync} : 8'h00;
        default: rdata_out <= 8'h00;
      endcase
      mux_sel_out <= channel;
      sample_out <= (state == ST_SAMPLE);
      low_power_out <= low_power_config;
      // Only flags the analogue use; the port keeps its digital function.
      analog_ch_enable_out <= chan_on;
      conv_irq_out <= (conv_done_flag || finish) && conv_irq_enable;
    end
  end

  a_irq_gating: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    conv_irq_out |-> $past(conv_irq_enable));
  a_done_sets: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (clk_en_in && finish) |=> conv_done_flag);
  a_done_readonly: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (clk_en_in && !finish && !conv_done_flag) |=> !conv_done_flag);
  a_stop_freeze: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (frozen && !wr_in) |=> $stable(state));
  a_result_right: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (rd_in && addr_in == `REG_RESULT_HI) |=> rdata_out[7:2] == 6'h00);
  a_lowpower_out: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (clk_en_in && wr_ck) |=> ##1 (!clk_en_in || low_power_out == $past(wdata_in[`CK_LOW_POWER_BIT], 2)));
  sequence s_long_start;
    clk_en_in && start && long_sample_select && !async_clock_enable;
  endsequence
  a_long_sample: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_long_start |=> (phase_cnt == `SAMPLE_LONG_CYC) ##0 (state == ST_SAMPLE) [*8]);
  a_pin_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (clk_en_in && $past(clk_en_in) && analog_ch_enable_out) |-> $past(chan_on));

  // Counts the converter clocks of the conversion in progress for the length check.
  logic [5:0] conv_ticks;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      conv_ticks <= 6'h00;
    end else if (clk_en_in) begin
      if (start || finish) begin
        conv_ticks <= 6'h00;
      end else if (step) begin
        conv_ticks <= 6'(conv_ticks + 6'h01);
      end
    end
  end
  a_conv_length: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (clk_en_in && finish) |->
      (6'(conv_ticks + 6'h01) >= `CONV_MIN_CYC) && (6'(conv_ticks + 6'h01) <= `CONV_MAX_CYC));
endmodule

// file: adc_front_end_model.sv
// Behavioural model of the analogue input pin and its comparator.
// Assumes the trial code comes straight from the converter control.
`timescale 1ns/1ns
module adc_front_end_model (
  // Analogue level.
  input wire logic [9:0] vin_in,
  // Trial code.
  input wire logic [9:0] dac_code_in,
  // Comparator.
  output logic comp_out
);
  // The pin direction stays input, so no digital drive disturbs the level.
  logic pin_drive_en;
  assign pin_drive_en = 1'b0;
  assign comp_out = !pin_drive_en && (vin_in >= dac_code_in);
endmodule

// file: adc_conversion_control_tb.sv
// Self-checking bench for the converter control through its register port.
// Assumes the comparator model above and a 10 MHz clock.
`timescale 1ns/1ns
module adc_conversion_control_tb;
  import adc_ctrl_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  byte_t wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic stop_mode_in = 1'b0;
  logic [9:0] vin = 10'h000;
  byte_t rdata_out;
  byte_t d;
  logic comp_in, sample_out, low_power_out, analog_ch_enable_out, conv_irq_out;
  logic [4:0] mux_sel_out;
  result_t dac_code_out;
  int fails = 0;
  int checked = 0;
  int n_short, n_long, n;
  adc_conversion_control uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .stop_mode_in(stop_mode_in), .comp_in(comp_in), .mux_sel_out(mux_sel_out),
    .sample_out(sample_out), .low_power_out(low_power_out), .dac_code_out(dac_code_out),
    .analog_ch_enable_out(analog_ch_enable_out), .conv_irq_out(conv_irq_out));
  adc_front_end_model fe (.vin_in(vin), .dac_code_in(dac_code_out), .comp_out(comp_in));
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input byte_t v);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata_out;
  endtask
  task automatic wait_done(input int lim, output int cyc);
    cyc = 0;
    d = 8'h00;
    while (d[7] !== 1'b1 && cyc < lim) begin
      rd(4'h0);
      cyc += 2;
    end
  endtask
  task automatic conv(input byte_t ck, input byte_t sc, input int lim, output int cyc);
    wr(4'h1, ck);
    wr(4'h0, sc);
    wait_done(lim, cyc);
  endtask
  function automatic logic in_range(input int cyc, input int rate);
    return (cyc / rate >= 21) && (cyc / rate <= 45);
  endfunction
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    fails++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(4'h0);
    chk(d, 16'h001F);
    rd(4'h1);
    chk(d, 16'h0000);
    rd(4'hF);
    chk(d, 16'h0000);
    chk(mux_sel_out, 16'h001F);
    chk(analog_ch_enable_out, 16'h0000);
    wr(4'h0, 8'h9F);
    rd(4'h0);
    chk(d, 16'h001F);
    $display("test reset values done");
    vin = 10'h2A5;
    conv(8'h00, 8'h03, 400, n_short);
    chk(in_range(n_short, 3), 16'h0001);
    chk(dac_code_out, 16'h0200);
    chk(d[7], 16'h0001);
    chk(conv_irq_out, 16'h0000);
    chk(mux_sel_out, 16'h0003);
    chk(analog_ch_enable_out, 16'h0001);
    rd(4'h2);
    chk(d, 16'h0002);
    rd(4'h3);
    chk(d, 16'h00A5);
    rd(4'h0);
    chk(d, 16'h0003);
    $display("test plain conversion done");
    vin = 10'h15A;
    conv(8'h10, 8'h43, 400, n_long);
    chk(conv_irq_out, 16'h0001);
    chk(16'(n_long - n_short), 16'h002A);
    chk(in_range(n_long, 3), 16'h0001);
    rd(4'h3);
    chk(d, 16'h005A);
    @(negedge ref_clk_in);
    chk(conv_irq_out, 16'h0000);
    $display("test long sample done");
    wr(4'h1, 8'h80);
    repeat (2) @(negedge ref_clk_in);
    chk(low_power_out, 16'h0001);
    rd(4'h1);
    chk(d, 16'h0080);
    $display("test low power done");
    vin = 10'h0FF;
    conv(8'h40, 8'h03, 400, n);
    chk(in_range(n, 4), 16'h0001);
    rd(4'h3);
    chk(d, 16'h00FF);
    $display("test divided clock done");
    @(posedge ref_clk_in);
    stop_mode_in <= 1'b1;
    conv(8'h00, 8'h03, 200, n);
    chk(d[7], 16'h0000);
    chk(sample_out, 16'h0001);
    conv(8'h01, 8'h03, 600, n);
    chk(d[7], 16'h0001);
    chk(in_range(n, 3), 16'h0001);
    conv(8'h11, 8'h03, 600, n);
    chk(d[7], 16'h0001);
    chk(in_range(n, 3), 16'h0001);
    $display("test stop mode done");
    final_report();
  end
endmodule
